// File: core/pwmrlb_pkg.sv
// Constants and types shared by the PWM run, load and brake control block
package pwmrlb_pkg;
    // Geometry
    localparam int NCH = 8;                 // PWM outputs
    localparam int CW  = 12;                // Counter and compare width
    localparam int AW  = 8;                 // APB address width
    localparam int DW  = 32;                // APB data width
    localparam int NFL = 2;                 // Sticky event flags

    // Register byte offsets
    localparam logic [AW-1:0] A_CTRL = 8'h00; // pwm_run_load_control_reg
    localparam logic [AW-1:0] A_BRK  = 8'h04; // brake_control_reg
    localparam logic [AW-1:0] A_BLVL = 8'h08; // brake_output_state_reg
    localparam logic [AW-1:0] A_FLAG = 8'h0C; // pwm_output_mode_flag_reg
    localparam logic [AW-1:0] A_INV  = 8'h10; // Per-output invert bits
    localparam logic [AW-1:0] A_MASK = 8'h14; // Interrupt mask
    localparam logic [AW-1:0] A_PER  = 8'h18; // Buffered period
    localparam logic [AW-1:0] A_CMP0 = 8'h20; // Buffered compare 0..7

    // Compare window decode
    localparam int CMP_LSB = 2;
    localparam int CMP_MSB = 4;

    // Field positions
    localparam int B_RUN  = 7;              // generator_run_bit
    localparam int B_LOAD = 6;              // Load request
    localparam int B_HALT = 7;              // brake_when_halted_select
    localparam int B_POL  = 6;              // brake_pin_polarity
    localparam int B_PEN  = 5;              // pin_brake_enable
    localparam int B_BEN  = 4;              // brake_enable_bit
    localparam int B_BKF  = 0;              // brake_flag
    localparam int B_LDF  = 1;              // Load-done flag

    // Reset values and masks
    localparam logic [7:0]     RST_8    = 8'h00;
    localparam logic [7:0]     BRK_WMSK = 8'hF0;
    localparam logic [CW-1:0]  RST_PER  = 12'hFFF;
    localparam logic [CW-1:0]  RST_CMP  = 12'h000;
    localparam logic [NFL-1:0] RST_FL   = 2'h0;
    localparam logic [DW-1:0]  RD_ZERO  = 32'h0000_0000;

    // Brake source selected by the control bits
    typedef enum logic [2:0] {BS_OFF, BS_ALWAYS, BS_HALTED, BS_PIN, BS_FLAG_ONLY} pwmrlb_bsrc_t;

    // Decode enable, halted select and pin enable into a source
    function automatic pwmrlb_bsrc_t pwmrlb_src(input logic ben, input logic halt,
                                                input logic pen);
        pwmrlb_bsrc_t s;
        s = BS_OFF;
        if (ben)
            s = halt ? (pen ? BS_FLAG_ONLY : BS_HALTED) : (pen ? BS_PIN : BS_ALWAYS);
        return s;
    endfunction
endpackage

// File: core/pwmrlb_gen_if.sv
// Control-to-generator link of the PWM block
interface pwmrlb_gen_if;
    import pwmrlb_pkg::*;
    logic                run;
    logic                load_req;
    logic [CW-1:0]       period;
    logic [CW-1:0]       cmp [NCH];
    logic [NCH-1:0]      wave;
    logic                load_done;
    modport ctl (output run, output load_req, output period, output cmp,
                 input wave, input load_done);
    modport gen (input run, input load_req, input period, input cmp,
                 output wave, output load_done);
endinterface

// File: core/pwmrlb_sync.sv
// Two-flop synchroniser for the external brake pin
module pwmrlb_sync
#(
    parameter int STAGES = 2
)
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic [STAGES-1:0] sh_reg;

    // Only the last stage is looked at
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sh_reg <= '0;
        else
            sh_reg <= {sh_reg[STAGES-2:0], d_i};
    end
    assign q_o = sh_reg[STAGES-1];

    property p_sync;
        @(posedge clk_i) disable iff (!rst_n_i) ##2 (q_o == $past(d_i, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("brake pin sync latency wrong");
endmodule // pwmrlb_sync

// File: core/pwmrlb_gen.sv
// Period counter, active registers and raw waveform of the eight outputs
module pwmrlb_gen
    import pwmrlb_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    pwmrlb_gen_if.gen   gi
);
    logic [CW-1:0]  cnt_reg;
    logic [CW-1:0]  per_act_reg;
    logic [CW-1:0]  cmp_act_reg [NCH];
    logic [NCH-1:0] wave_reg;
    logic           wrap;
    logic           xfer;

    // Transfer at period end, or at once while idle, so no glitch mid-period
    assign wrap         = gi.run && (cnt_reg >= per_act_reg);
    assign xfer         = gi.load_req && (!gi.run || wrap);
    assign gi.load_done = xfer;
    assign gi.wave      = wave_reg;

    // Counter stops while not running, which freezes the waveform
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_reg <= RST_CMP;
        else if (wrap)
            cnt_reg <= RST_CMP;
        else if (gi.run)
            cnt_reg <= cnt_reg + 1'b1;
    end

    // Buffered values become active
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            per_act_reg <= RST_PER;
        else if (xfer)
            per_act_reg <= gi.period;
    end

    genvar n;
    generate
        for (n = 0; n < NCH; n++)
        begin : g_ch
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    cmp_act_reg[n] <= RST_CMP;
                else if (xfer)
                    cmp_act_reg[n] <= gi.cmp[n];
            end

            // Output holds its level whenever the generator is stopped
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    wave_reg[n] <= 1'b0;
                else if (gi.run)
                    wave_reg[n] <= (cnt_reg < cmp_act_reg[n]);
            end
        end
    endgenerate

    property p_load;
        @(posedge clk_i) disable iff (!rst_n_i) xfer |=> per_act_reg == $past(gi.period);
    endproperty
    a_load: assert property (p_load) else $error("period not transferred");

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i) !gi.run |=> wave_reg == $past(wave_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("waveform moved while stopped");
endmodule // pwmrlb_gen

// File: core/pwmrlb_top.sv
// PWM run, load and brake control with APB register access
// How it works
// - each output has an invert bit that complements its waveform
// - setting load copies buffered period and compares into active registers
// - run bit set means generator runs, clear means idle; here any active brake also stops the generator while run is set
// - during brake all outputs show their brake-state register levels
// - with brake enabled, halted select and pin enable pick the source
// - halted select set with pin enable clear brakes whenever run is clear
// - pin brake acts when synchronised pin equals polarity bit
// - pin brake clears run and sets the brake flag
// - halted select plus pin enable only sets the flag
// - brake flag is readable and can raise the interrupt
// - after brake ends outputs resume their pre-brake levels
// - hardware clears load once the transfer is done
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
module pwmrlb_top
    import pwmrlb_pkg::*;
(
    input  wire logic           clk_sys_i,
    input  wire logic           rst_n_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [AW-1:0]  paddr_i,
    input  wire logic [DW-1:0]  pwdata_i,
    output logic [DW-1:0]       prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    input  wire logic           brake_pin_i,
    output logic [NCH-1:0]      pwm_o,
    output logic                irq_o
);
    logic           rst_s1_reg;
    logic           rst_n;
    logic           run_reg;
    logic           load_reg;
    logic [7:0]     brk_reg;
    logic [NCH-1:0] blvl_reg;
    logic [NFL-1:0] flag_reg;
    logic [NFL-1:0] flag_next;
    logic [NFL-1:0] mask_reg;
    logic [NCH-1:0] inv_reg;
    logic [CW-1:0]  per_reg;
    logic [CW-1:0]  cmp_reg [NCH];
    logic [NCH-1:0] pwm_reg;
    logic [NCH-1:0] pwm_next;
    logic [DW-1:0]  prdata_reg;
    logic [DW-1:0]  rd_val;
    logic [7:0]     ctrl_vec;
    logic           pin_s;
    logic           pin_act;
    logic           pin_evt;
    logic           pin_stop;
    logic           brake_on;
    pwmrlb_bsrc_t   bsrc;
    pwmrlb_gen_if   gi ();

    // Reset released through two flops, asserted at once
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // APB decode; zero wait states, unmapped addresses answer with an error
    wire acc     = psel_i && penable_i;
    wire wr      = acc && pwrite_i;
    wire h_ctrl  = (paddr_i == A_CTRL);
    wire h_brk   = (paddr_i == A_BRK);
    wire h_blvl  = (paddr_i == A_BLVL);
    wire h_flag  = (paddr_i == A_FLAG);
    wire h_inv   = (paddr_i == A_INV);
    wire h_mask  = (paddr_i == A_MASK);
    wire h_per   = (paddr_i == A_PER);
    wire h_cmp   = (paddr_i[AW-1:CMP_MSB+1] == A_CMP0[AW-1:CMP_MSB+1]);
    localparam int CIW = CMP_MSB - CMP_LSB + 1;
    wire [CIW-1:0] cidx = paddr_i[CMP_MSB:CMP_LSB];
    wire hit     = h_ctrl | h_brk | h_blvl | h_flag | h_inv | h_mask | h_per | h_cmp;
    wire w_ctrl  = wr && h_ctrl;
    wire w_set_ld = w_ctrl && pwdata_i[B_LOAD];
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && !hit;

    // Brake source decode and pin comparison
    assign bsrc     = pwmrlb_src(brk_reg[B_BEN], brk_reg[B_HALT], brk_reg[B_PEN]);
    assign pin_act  = (pin_s == brk_reg[B_POL]);
    assign pin_evt  = pin_act && (bsrc == BS_PIN || bsrc == BS_FLAG_ONLY);
    assign pin_stop = pin_act && (bsrc == BS_PIN);
    assign brake_on = (bsrc == BS_ALWAYS)
                    || (bsrc == BS_HALTED && !run_reg)
                    || (bsrc == BS_PIN && pin_act);

    // Generator link; stopping it during brake keeps the last levels
    assign gi.run      = run_reg && !brake_on;
    assign gi.load_req = load_reg;
    assign gi.period   = per_reg;
    assign gi.cmp      = cmp_reg;

    // Brake levels override, inversion applies only to the waveform
    assign pwm_next = brake_on ? blvl_reg : (gi.wave ^ inv_reg);
    assign pwm_o    = pwm_reg;

    // Sticky flags: a new event wins over a same-cycle clear
    assign flag_next = (flag_reg & ~((wr && h_flag) ? pwdata_i[NFL-1:0] : RST_FL))
                     | {gi.load_done, pin_evt};
    assign irq_o     = |(flag_reg & mask_reg);

    // Read view of the run/load register
    always_comb
    begin
        ctrl_vec         = RST_8;
        ctrl_vec[B_RUN]  = run_reg;
        ctrl_vec[B_LOAD] = load_reg;
    end

    assign rd_val = h_ctrl ? {24'h000000, ctrl_vec}
                  : h_brk  ? {24'h000000, brk_reg}
                  : h_blvl ? {24'h000000, blvl_reg}
                  : h_flag ? {30'h00000000, flag_reg}
                  : h_inv  ? {24'h000000, inv_reg}
                  : h_mask ? {30'h00000000, mask_reg}
                  : h_per  ? {20'h00000, per_reg}
                  : h_cmp  ? {20'h00000, cmp_reg[cidx]}
                  : RD_ZERO;
    assign prdata_o = prdata_reg;

    pwmrlb_sync #(.STAGES(2)) u_sync (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n),
        .d_i     (brake_pin_i),
        .q_o     (pin_s)
    );

    pwmrlb_gen u_gen (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n),
        .gi      (gi.gen)
    );

    // Read data captured in the setup phase, stable through access
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            prdata_reg <= RD_ZERO;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_reg <= rd_val;
    end

    // Run bit: a pin brake beats a software write, so a stuck pin wins
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            run_reg <= 1'b0;
        else if (pin_stop)
            run_reg <= 1'b0;
        else if (w_ctrl)
            run_reg <= pwdata_i[B_RUN];
    end

    // Load bit: set by software, cleared by hardware after the transfer
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            load_reg <= 1'b0;
        else if (w_set_ld)
            load_reg <= 1'b1;
        else if (gi.load_done)
            load_reg <= 1'b0;
    end

    // Flags, output register and plain configuration
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= RST_FL;
            pwm_reg  <= RST_8;
        end
        else
        begin
            flag_reg <= flag_next;
            pwm_reg  <= pwm_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brk_reg  <= RST_8;
            blvl_reg <= RST_8;
            inv_reg  <= RST_8;
            mask_reg <= RST_FL;
            per_reg  <= RST_PER;
        end
        else if (wr)
        begin
            if (h_brk)  brk_reg  <= pwdata_i[7:0] & BRK_WMSK;
            if (h_blvl) blvl_reg <= pwdata_i[NCH-1:0];
            if (h_inv)  inv_reg  <= pwdata_i[NCH-1:0];
            if (h_mask) mask_reg <= pwdata_i[NFL-1:0];
            if (h_per)  per_reg  <= pwdata_i[CW-1:0];
        end
    end

    genvar n;
    generate
        for (n = 0; n < NCH; n++)
        begin : g_cmp
            always_ff @(posedge clk_sys_i or negedge rst_n)
            begin
                if (!rst_n)
                    cmp_reg[n] <= RST_CMP;
                else if (wr && h_cmp && cidx == CIW'(n))
                    cmp_reg[n] <= pwdata_i[CW-1:0];
            end
        end
    endgenerate

    // Checks on the control behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    property p_inv;
        !brake_on |=> pwm_o == ($past(gi.wave) ^ $past(inv_reg));
    endproperty
    a_inv: assert property (p_inv) else $error("inverted waveform wrong");

    property p_load_req;
        w_set_ld && !pwdata_i[B_RUN] && !load_reg && !run_reg |=> gi.load_done;
    endproperty
    a_load_req: assert property (p_load_req) else $error("idle load not immediate");

    property p_run;
        w_ctrl && !pin_stop |=> run_reg == $past(pwdata_i[B_RUN]);
    endproperty
    a_run: assert property (p_run) else $error("run bit not written");

    property p_brk;
        brake_on |=> pwm_o == $past(blvl_reg);
    endproperty
    a_brk: assert property (p_brk) else $error("brake levels not shown");

    property p_always;
        bsrc == BS_ALWAYS ##1 bsrc == BS_ALWAYS |-> pwm_o == $past(blvl_reg);
    endproperty
    a_always: assert property (p_always) else $error("unconditional brake missing");

    property p_halted;
        brk_reg[B_BEN] && brk_reg[B_HALT] && !brk_reg[B_PEN] && !run_reg
            |=> pwm_o == $past(blvl_reg);
    endproperty
    a_halted: assert property (p_halted) else $error("halted brake missing");

    property p_pin;
        ##2 (bsrc == BS_PIN && $past(brake_pin_i, 2) == brk_reg[B_POL]) |-> brake_on;
    endproperty
    a_pin: assert property (p_pin) else $error("pin brake not asserted");

    property p_stop;
        pin_stop |=> !run_reg && flag_reg[B_BKF];
    endproperty
    a_stop: assert property (p_stop) else $error("pin brake kept running");

    property p_flag_only;
        bsrc == BS_FLAG_ONLY && pin_act
            |=> flag_reg[B_BKF] && pwm_o == ($past(gi.wave) ^ $past(inv_reg));
    endproperty
    a_flag_only: assert property (p_flag_only) else $error("flag-only mode braked");

    property p_run_keep;
        bsrc == BS_FLAG_ONLY && run_reg && !w_ctrl |=> run_reg;
    endproperty
    a_run_keep: assert property (p_run_keep) else $error("flag-only mode stopped run");

    property p_irq;
        flag_reg[B_BKF] && mask_reg[B_BKF] |-> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("brake interrupt missing");

    property p_ld_clr;
        gi.load_done && !w_set_ld |=> !load_reg;
    endproperty
    a_ld_clr: assert property (p_ld_clr) else $error("load bit not cleared");

    property p_bkf_keep;
        flag_reg[B_BKF] && !(wr && h_flag) |=> flag_reg[B_BKF];
    endproperty
    a_bkf_keep: assert property (p_bkf_keep) else $error("brake flag self-cleared");

    c_pin_stop:  cover property (pin_stop ##1 !run_reg);
    c_flag_only: cover property (bsrc == BS_FLAG_ONLY && pin_act);
    c_load:      cover property (load_reg && run_reg ##[1:300] gi.load_done);
    c_irq:       cover property ($rose(irq_o));
    c_halted:    cover property (bsrc == BS_HALTED && brake_on);
endmodule // pwmrlb_top

// File: verif/pwmrlb_partner.sv
// Far-side model: external brake pin driver and watcher of the PWM pins
module pwmrlb_partner
    import pwmrlb_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic [NCH-1:0] pwm_i,
    output logic                brake_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int             toggles;
    logic [NCH-1:0] pwm_q;

    // Pin is a driven level at all times, never left floating
    initial brake_pin_o = 1'h0;
    initial toggles = 0;

    // Count output activity, to show the pins were watched
    always @(posedge clk_i)
    begin
        pwm_q <= pwm_i;
        if (pwm_i !== pwm_q)
            toggles <= toggles + 1;
    end

    // Level change just after an edge, held until the next call
    task automatic set_pin(input logic lvl);
        @(posedge clk_i);
        brake_pin_o <= lvl;
    endtask
endmodule // pwmrlb_partner

// File: verif/pwm_run_load_brake_control_tb_top.sv
// Self-checking bench of the PWM run, load and brake control block
module pwm_run_load_brake_control_tb_top;
    import pwmrlb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk_sys_i = 1'h0;
    logic           rst_n_i = 1'h0;
    logic           psel = 1'h0;
    logic           penable = 1'h0;
    logic           pwrite = 1'h0;
    logic [AW-1:0]  paddr = 8'h00;
    logic [DW-1:0]  pwdata = 32'h0;
    logic [DW-1:0]  prdata;
    logic           pready;
    logic           pslverr;
    logic           brake_pin;
    logic [NCH-1:0] pwm;
    logic           irq;
    logic [DW-1:0]  rdata;
    logic           err;
    int             fail_count = 0;
    int             checked = 0;
    int             cyc = 0;
    int             inv, blvl, full, nf;

    // 40 MHz system clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    pwmrlb_top uut (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .psel_i      (psel),
        .penable_i   (penable),
        .pwrite_i    (pwrite),
        .paddr_i     (paddr),
        .pwdata_i    (pwdata),
        .prdata_o    (prdata),
        .pready_o    (pready),
        .pslverr_o   (pslverr),
        .brake_pin_i (brake_pin),
        .pwm_o       (pwm),
        .irq_o       (irq)
    );

    pwmrlb_partner far (
        .clk_i       (clk_sys_i),
        .pwm_i       (pwm),
        .brake_pin_o (brake_pin)
    );

    // Verdict in one place only
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            fail_count++;
            final_report();
        end
    end

    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys_i);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'h1;
        do
            @(posedge clk_sys_i);
        while (pready !== 1'h1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rdata, exp);
    endtask

    // Model of the pins: brake levels or compare result with invert
    task automatic pins(input int brk);
        repeat (5) @(posedge clk_sys_i);
        chk(32'(pwm), 32'(brk ? blvl : ((full ^ inv) & 8'hFF)));
    endtask

    initial
    begin
        void'($urandom(32'h25860212));
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'h1;
        repeat (4) @(posedge clk_sys_i);
        rdc(A_CTRL, 32'h0);
        rdc(A_BRK, 32'h0);
        rdc(A_FLAG, 32'h0);
        rdc(A_PER, 32'hFFF);
        rdc(8'h1C, 32'h0);
        chk(32'(err), 32'h1);
        inv = $urandom & 8'hFF;
        blvl = $urandom & 8'hFF;
        full = 0;
        wr(A_INV, 32'(inv));
        wr(A_BLVL, 32'(blvl));
        pins(0);
        // Unconditional brake; low bits of the brake register are dropped
        wr(A_BRK, 32'h1F);
        rdc(A_BRK, 32'h10);
        pins(1);
        wr(A_BRK, 32'h0);
        // Load while idle; outputs stay frozen until the generator runs
        nf = $urandom & 8'hFF;
        wr(A_PER, 32'h3);
        for (int n = 0; n < NCH; n++)
            wr(8'(A_CMP0 + 4 * n), nf[n] ? 32'hFFF : 32'h0);
        wr(A_CTRL, 32'h40);
        rdc(A_CTRL, 32'h0);
        rdc(A_FLAG, 32'h2);
        wr(A_FLAG, 32'h2);
        pins(0);
        // Brake while halted, released by run
        wr(A_BRK, 32'h90);
        pins(1);
        wr(A_CTRL, 32'h80);
        full = nf;
        pins(0);
        // Pin brake, both polarities, interrupt unmasked
        wr(A_MASK, 32'h1);
        for (int p = 0; p < 2; p++)
        begin
            // Polarity set with pin brake off, so no stray brake on the change
            wr(A_BRK, 32'(p << 6));
            far.set_pin(1'(~p));
            wr(A_BRK, 32'h30 | (p << 6));
            wr(A_CTRL, 32'h80);
            pins(0);
            far.set_pin(1'(p));
            pins(1);
            chk(32'(irq), 32'h1);
            rdc(A_CTRL, 32'h0);
            far.set_pin(1'(~p));
            pins(0);
            rdc(A_FLAG, 32'h1);
            wr(A_FLAG, 32'h1);
            rdc(A_FLAG, 32'h0);
            chk(32'(irq), 32'h0);
        end
        // Recovery through software brake, fixed compares and reload
        wr(A_BRK, 32'h10);
        pins(1);
        nf = $urandom & 8'hFF;
        for (int n = 0; n < NCH; n++)
            wr(8'(A_CMP0 + 4 * n), nf[n] ? 32'hFFF : 32'h0);
        wr(A_CTRL, 32'hC0);
        rdc(A_CTRL, 32'h80);
        wr(A_BRK, 32'h0);
        full = nf;
        pins(0);
        // Reload while running waits for the period wrap; poll load
        nf = $urandom & 8'hFF;
        for (int n = 0; n < NCH; n++)
            wr(8'(A_CMP0 + 4 * n), nf[n] ? 32'hFFF : 32'h0);
        wr(A_CTRL, 32'hC0);
        rdata = 32'h40;
        for (int k = 0; k < 8 && rdata[B_LOAD]; k++)
            apb(1'h0, A_CTRL, 32'h0);
        chk(rdata, 32'h80);
        full = nf;
        pins(0);
        wr(A_FLAG, 32'h2);
        // Pin only flags when halted select and pin enable are both set
        wr(A_MASK, 32'h0);
        wr(A_BRK, 32'hF0);
        wr(A_CTRL, 32'h80);
        far.set_pin(1'h1);
        pins(0);
        rdc(A_CTRL, 32'h80);
        rdc(A_FLAG, 32'h1);
        chk(32'(irq), 32'h0);
        far.set_pin(1'h0);
        wr(A_FLAG, 32'h1);
        rdc(A_FLAG, 32'h0);
        final_report();
    end
endmodule // pwm_run_load_brake_control_tb_top
